// *** hdl/dbcsp_regs.svh ***
// Constants of the burst-of-two common-I/O SRAM port
`ifndef DBCSP_REGS_SVH
`define DBCSP_REGS_SVH

// Organisation: 2M words of 36 bits, one address per two-beat burst
`define DBCSP_ADDR_W 20
`define DBCSP_DEPTH 1048576
`define DBCSP_DQ_W 36
`define DBCSP_LANE_W 9
`define DBCSP_LANES 4
`define DBCSP_BURST 2
`define DBCSP_WORD_W 72
`define DBCSP_WLANES 8

// Field positions of a burst word
`define DBCSP_BEAT0_LSB 0
`define DBCSP_BEAT1_LSB 36

// Read latency in forward-clock cycles
`define DBCSP_RD_LAT_DLL 2
`define DBCSP_RD_LAT_BYP 1

// Reset value and DLL lock time
`define DBCSP_MASK_RST 4'hF
`define DBCSP_DLL_LOCK_CYC 16'h0400

`endif

// *** hdl/dbcsp_pkg.sv ***
// Types of the burst-of-two common-I/O SRAM port
`include "dbcsp_regs.svh"

package dbcsp_pkg;

    typedef struct packed {
        logic [`DBCSP_DQ_W-1:0] data;
        logic [`DBCSP_LANES-1:0] mask_n;
    } dbcsp_beat_t;

    typedef struct packed {
        logic [`DBCSP_ADDR_W-1:0] addr;
        dbcsp_beat_t b0;
    } dbcsp_wbuf_t;

    typedef enum logic [2:0] {
        DLL_OFF = 3'h1,
        DLL_LOCKING = 3'h2,
        DLL_LOCKED = 3'h4
    } dbcsp_dll_st_t;

endpackage : dbcsp_pkg

// *** hdl/dbcsp_sync3.sv ***
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module dbcsp_sync3 (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic d,
    output logic q
);

    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic q_r;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            q_r <= 1'b0;
        end
        else
        begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r)
            begin
                q_r <= s3_r;
            end
        end
    end

    assign q = q_r;

endmodule : dbcsp_sync3

`default_nettype wire

// *** hdl/dbcsp_array.sv ***
// Byte-lane storage array of the SRAM
`timescale 1ns/1ps
`default_nettype none
`include "dbcsp_regs.svh"

module dbcsp_array (
    input wire logic clk,
    input wire logic we,
    input wire logic [`DBCSP_ADDR_W-1:0] waddr,
    input wire logic [`DBCSP_WORD_W-1:0] wdata,
    input wire logic [`DBCSP_WLANES-1:0] wlane_n,
    input wire logic [`DBCSP_ADDR_W-1:0] raddr,
    output logic [`DBCSP_WORD_W-1:0] rdata
);

    genvar g;

    generate
        for (g = 0; g < `DBCSP_WLANES; g = g + 1)
        begin : g_lane
            logic [`DBCSP_LANE_W-1:0] mem [0:`DBCSP_DEPTH-1];

            always_ff @(posedge clk)
            begin
                if (we && !wlane_n[g])
                begin
                    mem[waddr] <= wdata[g*`DBCSP_LANE_W +: `DBCSP_LANE_W];
                end
            end

            assign rdata[g*`DBCSP_LANE_W +: `DBCSP_LANE_W] = mem[raddr];
        end
    endgenerate

endmodule : dbcsp_array

`default_nettype wire

// *** hdl/dbcsp_port.sv ***
// Device side of the burst-of-two common-I/O synchronous SRAM
`timescale 1ns/1ps
`default_nettype none
`include "dbcsp_regs.svh"

module dbcsp_port #(
    parameter logic [15:0] DLL_LOCK_CYC = `DBCSP_DLL_LOCK_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic dll_on,
    output logic dll_locked,
    input wire logic fwd_clk,
    input wire logic fwd_clk_inv,
    input wire logic load_cmd_n,
    input wire logic rd_wr_n,
    input wire logic [`DBCSP_ADDR_W-1:0] sync_addr_in,
    input wire logic [`DBCSP_LANES-1:0] byte_lane_mask_n,
    input wire logic [`DBCSP_DQ_W-1:0] dq_i,
    output logic [`DBCSP_DQ_W-1:0] dq_o,
    output logic dq_oe,
    output logic echo_clk,
    output logic echo_clk_inv,
    output logic read_valid_out
);

    // ****************************************
    // Core clock: DLL enable and lock tracking
    // ****************************************
    logic dll_on_s;
    logic [15:0] lock_cnt_r;
    logic dll_locked_r;
    dbcsp_pkg::dbcsp_dll_st_t dll_st_r;

    dbcsp_sync3 u_dll_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d(dll_on),
        .q(dll_on_s)
    );

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            dll_st_r <= dbcsp_pkg::DLL_OFF;
            lock_cnt_r <= 16'h0000;
            dll_locked_r <= 1'b0;
        end
        else
        begin
            unique case (dll_st_r)
                dbcsp_pkg::DLL_OFF:
                begin
                    lock_cnt_r <= 16'h0000;
                    if (dll_on_s)
                    begin
                        dll_st_r <= dbcsp_pkg::DLL_LOCKING;
                    end
                end
                dbcsp_pkg::DLL_LOCKING:
                begin
                    lock_cnt_r <= lock_cnt_r + 16'h0001;
                    if (!dll_on_s)
                    begin
                        dll_st_r <= dbcsp_pkg::DLL_OFF;
                    end
                    else if (lock_cnt_r == DLL_LOCK_CYC - 16'h0001)
                    begin
                        dll_st_r <= dbcsp_pkg::DLL_LOCKED;
                    end
                end
                dbcsp_pkg::DLL_LOCKED:
                begin
                    if (!dll_on_s)
                    begin
                        dll_st_r <= dbcsp_pkg::DLL_OFF;
                    end
                end
                default:
                begin
                    dll_st_r <= dbcsp_pkg::DLL_OFF;
                end
            endcase
            dll_locked_r <= dll_on_s && dll_st_r == dbcsp_pkg::DLL_LOCKED;
        end
    end

    assign dll_locked = dll_locked_r;

    // ****************************************
    // Link side: reset and lock crossing
    // ****************************************
    logic rk1_r;
    logic rst_k_b;
    logic lk1_r;
    logic lk2_r;

    always_ff @(posedge fwd_clk)
    begin
        rk1_r <= rst_b;
        rst_k_b <= rk1_r;
        lk1_r <= dll_locked_r;
        lk2_r <= lk1_r;
    end

    // ****************************************
    // Command capture
    // ****************************************
    logic rd_cmd_r;
    logic wr_cmd_r;
    logic [`DBCSP_ADDR_W-1:0] cmd_addr_r;

    always_ff @(posedge fwd_clk)
    begin
        if (!rst_k_b)
        begin
            rd_cmd_r <= 1'b0;
            wr_cmd_r <= 1'b0;
        end
        else
        begin
            rd_cmd_r <= !load_cmd_n && rd_wr_n;
            wr_cmd_r <= !load_cmd_n && !rd_wr_n;
        end
    end

    always_ff @(posedge fwd_clk)
    begin
        if (!load_cmd_n)
        begin
            cmd_addr_r <= sync_addr_in;
        end
    end

    // ****************************************
    // Late-write buffer and commit
    // ****************************************
    logic wb_v_r;
    dbcsp_pkg::dbcsp_wbuf_t wb_r;
    dbcsp_pkg::dbcsp_beat_t wb_b1_r;
    logic [`DBCSP_WORD_W-1:0] arr_wdata;
    logic [`DBCSP_WLANES-1:0] arr_wlane_n;
    logic [`DBCSP_WORD_W-1:0] arr_rdata;

    always_ff @(posedge fwd_clk)
    begin
        if (!rst_k_b)
        begin
            wb_v_r <= 1'b0;
        end
        else
        begin
            wb_v_r <= wr_cmd_r;
        end
    end

    always_ff @(posedge fwd_clk)
    begin
        if (wr_cmd_r)
        begin
            wb_r.addr <= cmd_addr_r;
            wb_r.b0.data <= dq_i;
            wb_r.b0.mask_n <= byte_lane_mask_n;
        end
    end

    always_ff @(posedge fwd_clk_inv)
    begin
        if (!rst_k_b)
        begin
            wb_b1_r.mask_n <= `DBCSP_MASK_RST;
        end
        else if (wb_v_r)
        begin
            wb_b1_r.data <= dq_i;
            wb_b1_r.mask_n <= byte_lane_mask_n;
        end
    end

    assign arr_wdata = {wb_b1_r.data, wb_r.b0.data};
    assign arr_wlane_n = {wb_b1_r.mask_n, wb_r.b0.mask_n};

    dbcsp_array u_array (
        .clk(fwd_clk),
        .we(wb_v_r),
        .waddr(wb_r.addr),
        .wdata(arr_wdata),
        .wlane_n(arr_wlane_n),
        .raddr(cmd_addr_r),
        .rdata(arr_rdata)
    );

    // ****************************************
    // Read path with write-buffer merge
    // ****************************************
    logic rd_hit;
    logic [`DBCSP_WORD_W-1:0] rd_word;
    logic rd_p1_r;
    logic [`DBCSP_WORD_W-1:0] rd_w1_r;
    logic valid1_r;
    logic valid2_r;
    logic [`DBCSP_DQ_W-1:0] out_b0_r;
    logic [`DBCSP_DQ_W-1:0] out_hi_r;
    logic [`DBCSP_DQ_W-1:0] out_b1_r;
    genvar g;

    assign rd_hit = wb_v_r && wb_r.addr == cmd_addr_r;

    generate
        for (g = 0; g < `DBCSP_WLANES; g = g + 1)
        begin : g_merge
            assign rd_word[g*`DBCSP_LANE_W +: `DBCSP_LANE_W] =
                (rd_hit && !arr_wlane_n[g]) ?
                arr_wdata[g*`DBCSP_LANE_W +: `DBCSP_LANE_W] :
                arr_rdata[g*`DBCSP_LANE_W +: `DBCSP_LANE_W];
        end
    endgenerate

    always_ff @(posedge fwd_clk)
    begin
        if (!rst_k_b)
        begin
            rd_p1_r <= 1'b0;
            valid1_r <= 1'b0;
        end
        else
        begin
            rd_p1_r <= rd_cmd_r;
            valid1_r <= lk2_r ? rd_p1_r : rd_cmd_r;
        end
    end

    always_ff @(posedge fwd_clk)
    begin
        rd_w1_r <= rd_word;
        if (lk2_r)
        begin
            out_b0_r <= rd_w1_r[`DBCSP_BEAT0_LSB +: `DBCSP_DQ_W];
            out_hi_r <= rd_w1_r[`DBCSP_BEAT1_LSB +: `DBCSP_DQ_W];
        end
        else
        begin
            out_b0_r <= rd_word[`DBCSP_BEAT0_LSB +: `DBCSP_DQ_W];
            out_hi_r <= rd_word[`DBCSP_BEAT1_LSB +: `DBCSP_DQ_W];
        end
    end

    always_ff @(posedge fwd_clk_inv)
    begin
        if (!rst_k_b)
        begin
            valid2_r <= 1'b0;
        end
        else
        begin
            valid2_r <= valid1_r;
        end
        out_b1_r <= out_hi_r;
    end

    // ****************************************
    // Echo clocks and double-rate outputs
    // ****************************************
    logic ph_a_r;
    logic ph_b_r;
    logic ph;

    always_ff @(posedge fwd_clk)
    begin
        if (!rst_k_b)
        begin
            ph_a_r <= 1'b0;
        end
        else
        begin
            ph_a_r <= !ph_b_r;
        end
    end

    always_ff @(posedge fwd_clk_inv)
    begin
        if (!rst_k_b)
        begin
            ph_b_r <= 1'b0;
        end
        else
        begin
            ph_b_r <= ph_a_r;
        end
    end

    // High from forward rise to inverted rise
    assign ph = ph_a_r ^ ph_b_r;
    assign echo_clk = ph;
    assign echo_clk_inv = !ph;
    assign dq_o = ph ? out_b0_r : out_b1_r;
    assign read_valid_out = ph ? valid1_r : valid2_r;
    assign dq_oe = ph ? valid1_r : valid2_r;

    // ****************************************
    // Assertions
    // ****************************************
    logic link_off;

    // Also masks the link reset flops before their first clear
    assign link_off = !rst_b || !rst_k_b;

    sequence rd_dll_s;
        rd_cmd_r && lk2_r ##1 lk2_r;
    endsequence

    sequence rd_idle_s;
        !rd_cmd_r ##1 !rd_cmd_r;
    endsequence

    cmd_exclusive_a: assert property (
        @(posedge fwd_clk) disable iff (link_off)
        !(rd_cmd_r && wr_cmd_r))
        else $error("read and write captured on one edge");

    read_lat_dll_a: assert property (
        @(posedge fwd_clk) disable iff (link_off)
        rd_dll_s |=> valid1_r)
        else $error("first read beat late with DLL locked");

    read_lat_byp_a: assert property (
        @(posedge fwd_clk) disable iff (link_off)
        rd_cmd_r && !lk2_r |=> valid1_r)
        else $error("first read beat late in bypass mode");

    second_beat_a: assert property (
        @(posedge fwd_clk) disable iff (link_off)
        valid2_r == valid1_r)
        else $error("second read beat not on inverted edge");

    bus_release_a: assert property (
        @(posedge fwd_clk) disable iff (link_off)
        rd_idle_s |=> !valid1_r && !dq_oe)
        else $error("bus driven without a read");

    write_buf_a: assert property (
        @(posedge fwd_clk) disable iff (link_off)
        wr_cmd_r |=> wb_v_r && wb_r.addr == $past(cmd_addr_r))
        else $error("write address not held for data");

    merge_hit_a: assert property (
        @(posedge fwd_clk) disable iff (link_off)
        rd_hit && !wb_r.b0.mask_n[0] |=>
        rd_w1_r[8:0] == $past(wb_r.b0.data[8:0]))
        else $error("buffered write byte not returned");

    mask_skip_a: assert property (
        @(posedge fwd_clk) disable iff (link_off)
        rd_hit && wb_r.b0.mask_n[0] |=>
        rd_w1_r[8:0] == $past(arr_rdata[8:0]))
        else $error("masked byte taken from write");

    echo_high_a: assert property (
        @(posedge fwd_clk_inv) disable iff (link_off)
        $past(rst_k_b) |-> echo_clk && !echo_clk_inv)
        else $error("echo clock not high before inverted edge");

    echo_low_a: assert property (
        @(posedge fwd_clk) disable iff (link_off)
        $past(rst_k_b) |-> !echo_clk && read_valid_out == valid2_r)
        else $error("echo clock not low before forward edge");

    dll_off_a: assert property (@(posedge clk) disable iff (!rst_b)
        !dll_on_s |=> dll_st_r == dbcsp_pkg::DLL_OFF && !dll_locked_r)
        else $error("DLL state kept while bypassed");

endmodule : dbcsp_port

`default_nettype wire

// *** verif/dbcsp_ctrl_model.sv ***
// Memory controller model driving the link side of the SRAM port
`timescale 1ns/1ps
`default_nettype none
`include "dbcsp_regs.svh"

module dbcsp_ctrl_model (
    output logic fwd_clk,
    output logic fwd_clk_inv,
    output logic load_cmd_n,
    output logic rd_wr_n,
    output logic [`DBCSP_ADDR_W-1:0] sync_addr_in,
    output logic [`DBCSP_LANES-1:0] byte_lane_mask_n,
    output logic [`DBCSP_DQ_W-1:0] ctrl_dq,
    output logic ctrl_oe
);
    typedef struct packed {
        logic [1:0] kind;
        logic [`DBCSP_ADDR_W-1:0] addr;
        logic [`DBCSP_WORD_W-1:0] data;
        logic [`DBCSP_WLANES-1:0] mask;
    } dbcsp_cmd_t;

    dbcsp_cmd_t sched[$];
    int rd_edges[$];
    int edge_cnt = 0;
    dbcsp_cmd_t cur = '0;
    dbcsp_cmd_t nxt = '0;
    logic wr_at_r = 1'b0;
    logic b1_pend = 1'b0;
    logic [35:0] b1_d = '0;
    logic [3:0] b1_m = 4'hF;

    assign fwd_clk_inv = ~fwd_clk;

    // Kind 0 idle, 1 write, 2 read
    task push(input logic [1:0] kind, input logic [19:0] a,
        input logic [71:0] d, input logic [7:0] m);
        sched.push_back(dbcsp_cmd_t'{kind, a, d, m});
    endtask : push

    initial
    begin
        fwd_clk = 1'b0;
        load_cmd_n = 1'b1;
        rd_wr_n = 1'b1;
        sync_addr_in = '0;
        byte_lane_mask_n = 4'hF;
        ctrl_dq = '0;
        ctrl_oe = 1'b0;
        #7;
        forever #40 fwd_clk = ~fwd_clk;
    end

    // Command launch, stable around the next rising edge
    always @(posedge fwd_clk)
    begin
        #2;
        edge_cnt++;
        if (b1_pend)
        begin
            ctrl_dq = b1_d;
            byte_lane_mask_n = b1_m;
            b1_pend = 1'b0;
        end
        wr_at_r = (nxt.kind == 2'h1);
        cur = nxt;
        nxt = (sched.size() > 0) ? sched.pop_front() : '0;
        load_cmd_n = (nxt.kind == 2'h0);
        rd_wr_n = (nxt.kind == 2'h0) ? 1'($urandom) : (nxt.kind == 2'h2);
        sync_addr_in = (nxt.kind == 2'h0) ? 20'($urandom) : nxt.addr;
        if (nxt.kind == 2'h2)
            rd_edges.push_back(edge_cnt + 1);
    end

    // First write beat, or release of the shared bus
    always @(posedge fwd_clk_inv)
    begin
        #2;
        if (wr_at_r)
        begin
            ctrl_oe = 1'b1;
            ctrl_dq = cur.data[35:0];
            byte_lane_mask_n = cur.mask[3:0];
            b1_d = cur.data[71:36];
            b1_m = cur.mask[7:4];
            b1_pend = 1'b1;
            wr_at_r = 1'b0;
        end
        else
        begin
            ctrl_oe = 1'b0;
            byte_lane_mask_n = 4'($urandom);
        end
    end
endmodule : dbcsp_ctrl_model
`default_nettype wire

// *** verif/tb_ddr_burst2_cio_sram_port.sv ***
// Self-checking bench of the SRAM port against a controller model
`timescale 1ns/1ps
`default_nettype none
`include "dbcsp_regs.svh"

`define CHK(nm, got, exp) \
    begin \
        compares++; \
        if ((got) !== (exp)) \
        begin \
            err_count++; \
            $display("mismatch %s exp %h got %h", nm, exp, got); \
        end \
    end

module tb_ddr_burst2_cio_sram_port;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic dll_on = 1'b0;
    logic dll_locked, fwd_clk, fwd_clk_inv, load_cmd_n, rd_wr_n;
    logic [19:0] sync_addr_in;
    logic [3:0] byte_lane_mask_n;
    logic [35:0] dq_i, dq_o, ctrl_dq;
    logic [35:0] idle_pat = 36'hA5A5A5A5A;
    logic dq_oe, ctrl_oe, echo_clk, echo_clk_inv, read_valid_out;
    int err_count = 0;
    int compares = 0;
    int exp_lat = 1;
    logic chk_on = 1'b0;
    logic exp_v = 1'b0;
    logic b1_exp = 1'b0;
    logic [71:0] rd_w = '0;
    logic [71:0] exq[$];
    logic [71:0] ref_mem [logic [19:0]];
    logic [19:0] pool [8];

    // Released bus shows a changing pattern
    assign dq_i = dq_oe ? dq_o : (ctrl_oe ? ctrl_dq : idle_pat);
    always @(posedge clk) idle_pat <= ~idle_pat;

    initial
    begin
        forever #12.5 clk = ~clk;
    end

    dbcsp_ctrl_model u_ctrl (.fwd_clk(fwd_clk), .fwd_clk_inv(fwd_clk_inv),
        .load_cmd_n(load_cmd_n), .rd_wr_n(rd_wr_n),
        .sync_addr_in(sync_addr_in), .byte_lane_mask_n(byte_lane_mask_n),
        .ctrl_dq(ctrl_dq), .ctrl_oe(ctrl_oe));

    dbcsp_port #(.DLL_LOCK_CYC(16'h0008)) u_dut (.clk(clk), .rst_b(rst_b),
        .dll_on(dll_on), .dll_locked(dll_locked), .fwd_clk(fwd_clk),
        .fwd_clk_inv(fwd_clk_inv), .load_cmd_n(load_cmd_n),
        .rd_wr_n(rd_wr_n), .sync_addr_in(sync_addr_in),
        .byte_lane_mask_n(byte_lane_mask_n), .dq_i(dq_i), .dq_o(dq_o),
        .dq_oe(dq_oe), .echo_clk(echo_clk), .echo_clk_inv(echo_clk_inv),
        .read_valid_out(read_valid_out));

    function automatic logic [71:0] merge(input logic [71:0] o,
        input logic [71:0] n, input logic [7:0] m);
        for (int l = 0; l < 8; l++)
            if (!m[l])
                o[9*l +: 9] = n[9*l +: 9];
        return o;
    endfunction : merge

    // Random traffic with a fixed corner prefix, no bus clashes
    task automatic gen(input int n);
        bit busy [0:127];
        int crn [6] = '{1, 2, 0, 0, 1, 2};
        int k;
        logic [19:0] a;
        logic [71:0] d;
        logic [7:0] m;
        busy = '{default: 0};
        for (int e = 0; e < n; e++)
        begin
            k = (e < 6) ? crn[e] : $urandom_range(2);
            a = (e < 6) ? pool[1] : pool[$urandom_range(7)];
            d = 72'({$urandom(), $urandom(), $urandom()});
            m = (e == 4) ? 8'hA5 : 8'($urandom);
            if (!ref_mem.exists(a))
            begin
                m = 8'h00;
                if (k == 2)
                    k = 0;
            end
            if (k == 1 && (busy[e] || busy[e+1]))
                k = 0;
            if (k == 2 && busy[e+exp_lat])
                k = 0;
            if (k == 1)
            begin
                busy[e] = 1;
                busy[e+1] = 1;
                ref_mem[a] = merge(ref_mem.exists(a) ? ref_mem[a] : '0, d, m);
            end
            if (k == 2)
            begin
                busy[e+exp_lat] = 1;
                exq.push_back(ref_mem[a]);
            end
            u_ctrl.push(2'(k), a, d, m);
        end
    endtask : gen

    task automatic run_phase(input int lat);
        exp_lat = lat;
        `CHK("dll_locked", dll_locked, (lat == 2))
        @(posedge fwd_clk);
        chk_on = 1'b1;
        gen(60);
        // Drain the schedule first, then the reads in flight
        for (int i = 0; i < 300 &&
            (u_ctrl.sched.size() > 0 || u_ctrl.rd_edges.size() > 0); i++)
            @(posedge fwd_clk);
        repeat (4) @(posedge fwd_clk);
        `CHK("reads_left", exq.size(), 0)
        chk_on = 1'b0;
    endtask : run_phase

    always @(posedge fwd_clk)
    begin
        #3;
        if (chk_on)
        begin
            exp_v = (u_ctrl.rd_edges.size() > 0) &&
                (u_ctrl.rd_edges[0] + exp_lat == u_ctrl.edge_cnt);
            `CHK("echo_clk", echo_clk, 1'b1)
            `CHK("echo_clk_inv", echo_clk_inv, 1'b0)
            `CHK("read_valid_out", read_valid_out, exp_v)
            `CHK("dq_oe", dq_oe, exp_v)
            b1_exp = exp_v;
            if (exp_v)
            begin
                void'(u_ctrl.rd_edges.pop_front());
                rd_w = exq.pop_front();
                `CHK("beat0", dq_o, rd_w[35:0])
            end
        end
    end

    always @(posedge fwd_clk_inv)
    begin
        #3;
        if (chk_on)
        begin
            `CHK("echo_clk_low", echo_clk, 1'b0)
            `CHK("valid_beat1", read_valid_out, b1_exp)
            if (b1_exp)
                `CHK("beat1", dq_o, rd_w[71:36])
        end
    end

    task final_report;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report

    initial
    begin
        #200000;
        err_count++;
        final_report();
    end

    initial
    begin
        void'($urandom(36));
        pool[0] = 20'h00000;
        pool[1] = 20'hFFFFF;
        for (int i = 2; i < 8; i++)
            pool[i] = 20'($urandom);
        // Long enough for three link edges as well
        repeat (10) @(posedge clk);
        #2 rst_b = 1'b1;
        repeat (8) @(posedge fwd_clk);
        run_phase(1);
        @(posedge clk);
        #2 dll_on = 1'b1;
        for (int i = 0; i < 300 && dll_locked !== 1'b1; i++)
            @(posedge clk);
        repeat (6) @(posedge fwd_clk);
        run_phase(2);
        @(posedge clk);
        #2 dll_on = 1'b0;
        for (int i = 0; i < 300 && dll_locked !== 1'b0; i++)
            @(posedge clk);
        repeat (6) @(posedge fwd_clk);
        run_phase(1);
        final_report();
    end
endmodule : tb_ddr_burst2_cio_sram_port
`default_nettype wire
